// ### dv/ptm_tb.sv
// Self-checking bench for the periodic timer unit: AXI4-Lite accesses and pin checks.
// Assumes ptm_top with the register map and codes of ptm_pkg, one 20 MHz clock.
`timescale 1ns/1ps
module testbench;
  import ptm_pkg::*;
  logic clk_in;
  logic resetn_in;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd_val;
  logic awvalid, wvalid, awready, wready, bvalid, arvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic cap_pin, clk_pin, pin, pin_oe;
  int errors, tests_run;

  // Ready lines stay high: a response is taken at the first edge it shows
  ptm_top ptm_top_i (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
    .capture_input_pin_in(cap_pin), .timer_clock_pin_in(clk_pin),
    .timer_output_pin_out(pin), .timer_output_pin_oe_out(pin_oe)
  );

  // ==========================================================
  // Clock, watchdog and verdict
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // About 37k cycles of tests; 50k cycles leaves margin
  initial begin
    #2_500_000;
    errors++;
    summarize();
  end

  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus tasks; each is entered just after a rising edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    resp = bresp;
    if (n >= 50) errors++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rd_val = rdata;
    resp = rresp;
    if (n >= 50) errors++;
  endtask

  // Mode and action change only with the counter off, then a clean restart
  task automatic start(input logic [7:0] c1);
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_CTRL1, {24'h0, c1});
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_CTRL0, 32'h8);
    repeat (3) @(posedge clk_in);
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      rd(OFS_FLAGS);
      n++;
    end while (rd_val[b] !== 1'b1 && n < 100);
    chk(rd_val[b], 1'b1);
  endtask

  // Period is P+1 counts (P of zero: 1024); 5120 holds whole periods of 20 and 1024
  task automatic pwm(input logic [1:0] act, input logic lvl, input logic inv,
                     input logic [9:0] a, input logic [9:0] p, input int hi, input int fl);
    int h;
    h = 0;
    wr(OFS_COMPA, {22'h0, a});
    wr(OFS_COMPP, {22'h0, p});
    start({2'h2, act, lvl, inv, 2'h1});
    repeat (5120) begin
      @(posedge clk_in);
      if (pin === 1'b1) h++;
    end
    chk(h, hi);
    chk(pin_oe, 1'b1);
    rd(OFS_FLAGS);
    chk(rd_val, fl);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    logic [1:0] act;
    logic lvl, inv, ex;
    errors = 0;
    tests_run = 0;
    resetn_in = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    cap_pin = 1'b0;
    clk_pin = 1'b0;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk(pin, 1'b0);
    rd(OFS_CTRL1);
    chk(rd_val, CTRL1_RESET);
    rd(8'h40);
    chk(resp, RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(resp, RESP_SLVERR);
    // Compare mode, every action with both initial levels
    wr(OFS_COMPA, 32'h14);
    wr(OFS_COMPP, 32'h0);
    for (int i = 0; i < 8; i++) begin
      act = i[1:0];
      lvl = i[2];
      inv = i[2] ^ i[1];
      ex = (act == 2'h0) ? lvl : (act == 2'h1) ? 1'b0 : (act == 2'h2) ? 1'b1 : ~lvl;
      start({2'h0, act, lvl, inv, 2'h0});
      chk(pin, lvl ^ inv);
      wait_flag(FLAG_A_BIT);
      chk(pin, ex ^ inv);
      rd(OFS_COUNT);
      chk(rd_val > 32'h14, 1'b1);
    end
    // Clear select and flags in compare and timer modes
    for (int m = 0; m < 2; m++) begin
      wr(OFS_COMPA, 32'ha);
      wr(OFS_COMPP, 32'h1e);
      start({m ? 2'h3 : 2'h0, 6'h0});
      repeat (80) @(posedge clk_in);
      chk(pin_oe, m == 0);
      rd(OFS_FLAGS);
      chk(rd_val, 32'h3);
      rd(OFS_COUNT);
      chk(rd_val <= 32'h1e, 1'b1);
      wr(OFS_COMPA, 32'h1e);
      wr(OFS_COMPP, 32'ha);
      start({m ? 2'h3 : 2'h0, 6'h1});
      repeat (80) @(posedge clk_in);
      rd(OFS_FLAGS);
      chk(rd_val, 32'h1);
      rd(OFS_COUNT);
      chk(rd_val <= 32'h1e, 1'b1);
    end
    wr(OFS_CTRL0, 32'h0);
    rd(OFS_COUNT);
    ex = 1'b0;
    wdata <= rd_val;
    repeat (10) @(posedge clk_in);
    rd(OFS_COUNT);
    chk(rd_val, wdata);
    wr(OFS_CTRL0, 32'h8);
    rd(OFS_COUNT);
    chk(rd_val < 32'h8, 1'b1);
    // PWM and forced levels
    pwm(2'h2, 1'b1, 1'b0, 10'd5, 10'd19, 1280, 3);
    pwm(2'h2, 1'b0, 1'b0, 10'd5, 10'd19, 3840, 3);
    pwm(2'h2, 1'b1, 1'b1, 10'd5, 10'd19, 3840, 3);
    pwm(2'h2, 1'b1, 1'b0, 10'd25, 10'd19, 5120, 2);
    pwm(2'h2, 1'b1, 1'b0, 10'd256, 10'd0, 1280, 3);
    pwm(2'h0, 1'b1, 1'b0, 10'd5, 10'd19, 0, 3);
    pwm(2'h1, 1'b1, 1'b0, 10'd5, 10'd19, 5120, 3);
    // Single pulse ends on match A
    wr(OFS_COMPA, 32'h32);
    start(8'hb8);
    repeat (200) @(posedge clk_in);
    rd(OFS_CTRL0);
    chk(rd_val, 32'h0);
    chk(pin, 1'b0);
    // Capture edges and trigger source
    wr(OFS_COMPP, 32'h0);
    for (int i = 0; i < 8; i++) begin
      act = i[1:0];
      cap_pin <= 1'b0;
      clk_pin <= 1'b0;
      start({2'h1, act, 2'h0, i[2], 1'b0});
      if (i[2]) cap_pin <= 1'b1;
      else clk_pin <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd(OFS_FLAGS);
      chk(rd_val, 32'h0);
      if (i[2]) clk_pin <= 1'b1;
      else cap_pin <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd(OFS_FLAGS);
      chk(rd_val[0], act == 2'h0 || act == 2'h2);
      wr(OFS_FLAGS, 32'h1);
      if (i[2]) clk_pin <= 1'b0;
      else cap_pin <= 1'b0;
      repeat (4) @(posedge clk_in);
      rd(OFS_FLAGS);
      chk(rd_val[0], act == 2'h1 || act == 2'h2);
    end
    summarize();
  end
endmodule

// ### hdl/ptm_capture.sv
// Capture trigger source select and edge detector.
// Assumes both trigger pins are synchronous to clk_in.
`timescale 1ns/1ps
module ptm_capture (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pins
  input wire logic capture_input_pin_in,
  input wire logic timer_clock_pin_in,
  // Control
  input wire logic enable_in,
  input wire logic capture_source_select_in,
  input wire logic [1:0] edge_sel_in,
  // Event
  output logic event_out
);
  import ptm_pkg::*;

  logic prev_reg, prev_next;
  logic trig, rise, fall;

  // ==========================================================
  // Edge detection
  assign trig = capture_source_select_in ? timer_clock_pin_in : capture_input_pin_in;
  assign rise = trig & ~prev_reg;
  assign fall = ~trig & prev_reg;
  assign prev_next = trig;

  always_comb begin
    event_out = 1'b0;
    if (enable_in) begin
      unique case (edge_sel_in)
        CAP_RISE: event_out = rise;
        CAP_FALL: event_out = fall;
        CAP_BOTH: event_out = rise | fall;
        CAP_OFF: event_out = 1'b0;
      endcase
    end
  end

  // Source change can fake one edge; software should switch while off
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  chk_cap_off: assert property (
    @(posedge clk_in) disable iff (!resetn_in) (edge_sel_in == CAP_OFF) |-> !event_out)
    else $error("capture fired while disabled");

  chk_cap_rise: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (enable_in && edge_sel_in == CAP_RISE && !capture_source_select_in &&
     capture_input_pin_in && !$past(capture_input_pin_in) &&
     $past(capture_source_select_in) == capture_source_select_in) |-> event_out)
    else $error("rising edge on capture pin missed");

endmodule

// ### hdl/ptm_counter.sv
// 10-bit up counter with comparators A and P.
// Assumes run_in and restart_in come from the control flops of the top.
`timescale 1ns/1ps
module ptm_counter (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic clear_on_a_in,
  input wire logic [ptm_pkg::CNT_W-1:0] compa_in,
  input wire logic [ptm_pkg::CNT_W-1:0] compp_in,
  // Status
  output logic [ptm_pkg::CNT_W-1:0] count_out,
  output ptm_pkg::ptm_match_s match_out
);
  import ptm_pkg::*;

  logic [CNT_W-1:0] count_reg, count_next;
  logic live, hit_a, hit_p;

  // ==========================================================
  // Comparators
  // The restart cycle still shows the old value, so matches are masked then
  assign live = run_in & ~restart_in;
  assign hit_a = live & (count_reg == compa_in);
  assign hit_p = live & ((compp_in == CNT_ZERO) ? (count_reg == CNT_MAX) :
                         (count_reg == compp_in));
  // One driver for the whole struct keeps strict tools happy
  assign match_out = '{a: hit_a, p: hit_p};
  assign count_out = count_reg;

  // ==========================================================
  // Counter
  always_comb begin
    count_next = count_reg;
    if (restart_in) begin
      count_next = CNT_ZERO;
    end else if (run_in) begin
      if (clear_on_a_in ? hit_a : hit_p) begin
        count_next = CNT_ZERO;
      end else begin
        count_next = count_reg + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  chk_restart_zero: assert property (
    @(posedge clk_in) disable iff (!resetn_in) restart_in |=> count_reg == CNT_ZERO)
    else $error("counter not zero after restart");

  chk_hold_off: assert property (
    @(posedge clk_in) disable iff (!resetn_in) !run_in |=> $stable(count_reg))
    else $error("counter moved while off");

  chk_clear_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clear_on_a_in && match_out.a) |=> count_reg == CNT_ZERO)
    else $error("counter not cleared by match A");

endmodule

// ### hdl/ptm_pkg.sv
// Constants, register map and carrier types of the periodic timer unit.
// Assumes a single 20 MHz clock domain and an AXI4-Lite register slave.
package ptm_pkg;

  // ==========================================================
  // Sizes and timing
  localparam int CNT_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CLK_PERIOD_NS = 50;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COMPA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_COMPP = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;
  localparam int CTRL0_ON_BIT = 3;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Modes and action codes
  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_CAP = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TC = 2'h3
  } ptm_mode_e;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;
  localparam logic [1:0] PWM_SINGLE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] CAP_OFF = 2'h3;

  // ==========================================================
  // Carriers
  typedef struct packed {
    ptm_mode_e mode;
    logic [1:0] action;
    logic init_level;
    logic invert;
    logic cap_src;
    logic clr_sel;
  } ptm_ctrl1_s;

  typedef struct packed {
    logic a;
    logic p;
  } ptm_match_s;

endpackage

// ### hdl/ptm_top.sv
// Periodic timer unit: AXI4-Lite register slave, mode control and pin logic.
// Assumes one 20 MHz clock, synchronous pins and an external pad for the pin.
//
// Contract
// - Compare mode, match A: 00 keep, 01 low, 10 high, 11 toggle pin.
// - PWM mode action: 00 inactive, 01 active, 10 waveform, 11 single pulse.
// - Capture action: 00 rising, 01 falling, 10 both edges, 11 disabled.
// - Counter-on rising edge restores pin to its initial level in compare mode.
// - Level bit: initial level in compare, active level in PWM, unused in timer.
// - Invert bit flips the pin; no effect in timer/counter mode.
// - Capture source: 0 capture pin, 1 timer clock pin.
// - Clear select 1 clears on match A; 0 on match P or overflow.
// - Clear select ignored in PWM, single pulse and capture modes.
// - Compare mode with clear select 0 sets both match flags.
// - Compare mode with clear select 1 never sets the P flag.
// - Of the two matches, only match A changes the pin in compare mode.
// - Timer/counter mode acts like compare mode but leaves the pin undriven.
// - PWM: P sets period and clears, A sets duty, both flag.
// - P of zero gives 1024-count period; duty at or above period is 100%.
// - PWM generation keeps running while the output is forced.
// - Counter-on rising clears the counter; falling holds the value.
`timescale 1ns/1ps
module ptm_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // AXI4-Lite write address and data
  input wire logic [ptm_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [ptm_pkg::DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [ptm_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [ptm_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins
  input wire logic capture_input_pin_in,
  input wire logic timer_clock_pin_in,
  output logic timer_output_pin_out,
  output logic timer_output_pin_oe_out
);
  import ptm_pkg::*;

  // ==========================================================
  // Declarations
  logic on_reg, on_next, on_prev_reg;
  ptm_ctrl1_s ctrl1_reg, ctrl1_next;
  logic [CNT_W-1:0] compa_reg, compa_next, compp_reg, compp_next, count;
  logic flag_a_reg, flag_a_next, flag_p_reg, flag_p_next;
  logic level_reg, level_next, pin_reg, pin_next, oe_reg, oe_next;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [DATA_W-1:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, wready_reg, bvalid_reg, bvalid_next, arready_reg, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  ptm_match_s match;
  logic restart, is_cmp, is_cap, is_pwm, is_tc, clear_on_a, single, pwm_active;
  logic cap_evt, a_set, p_set, do_write, wr_hit, ar_take, flag_clr, base, force_lvl;

  function automatic logic [CNT_W-1:0] merge10(input logic [CNT_W-1:0] old,
                                               input logic [DATA_W-1:0] data,
                                               input logic [3:0] strb);
    merge10 = {strb[1] ? data[CNT_W-1:8] : old[CNT_W-1:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // Mode decode
  assign restart = on_reg & ~on_prev_reg;
  assign is_cmp = ctrl1_reg.mode == MODE_CMP;
  assign is_cap = ctrl1_reg.mode == MODE_CAP;
  assign is_pwm = ctrl1_reg.mode == MODE_PWM;
  assign is_tc = ctrl1_reg.mode == MODE_TC;
  // Single pulse ignores compare P, so only match A may end the count
  assign clear_on_a = ((is_cmp | is_tc) & ctrl1_reg.clr_sel) | single;
  assign single = is_pwm & (ctrl1_reg.action == PWM_SINGLE);
  assign a_set = is_cap ? cap_evt : match.a;
  assign p_set = match.p & ~clear_on_a & ~single;
  // Duty at or above a nonzero period stays active through the P match count
  assign pwm_active = (count < compa_reg) ||
                      ((compp_reg != CNT_ZERO) && (compa_reg >= compp_reg));
  assign force_lvl = ~ctrl1_reg.init_level ^ ctrl1_reg.invert;

  ptm_counter u_counter (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(on_reg),
    .restart_in(restart),
    .clear_on_a_in(clear_on_a),
    .compa_in(compa_reg),
    .compp_in(compp_reg),
    .count_out(count),
    .match_out(match)
  );

  ptm_capture u_capture (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .capture_input_pin_in(capture_input_pin_in),
    .timer_clock_pin_in(timer_clock_pin_in),
    .enable_in(is_cap & on_reg),
    .capture_source_select_in(ctrl1_reg.cap_src),
    .edge_sel_in(ctrl1_reg.action),
    .event_out(cap_evt)
  );

  // ==========================================================
  // AXI4-Lite handshakes
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign ar_take = s_axi_arvalid_in & arready_reg;
  assign wr_hit = (aw_addr_reg == OFS_CTRL0) || (aw_addr_reg == OFS_CTRL1) ||
                  (aw_addr_reg == OFS_COUNT) || (aw_addr_reg == OFS_COMPA) ||
                  (aw_addr_reg == OFS_COMPP) || (aw_addr_reg == OFS_FLAGS);

  always_comb begin
    aw_full_next = aw_full_reg ? ~do_write : (s_axi_awvalid_in & awready_reg);
    w_full_next = w_full_reg ? ~do_write : (s_axi_wvalid_in & wready_reg);
    aw_addr_next = (s_axi_awvalid_in & awready_reg) ? s_axi_awaddr_in : aw_addr_reg;
    w_data_next = (s_axi_wvalid_in & wready_reg) ? s_axi_wdata_in : w_data_reg;
    w_strb_next = (s_axi_wvalid_in & wready_reg) ? s_axi_wstrb_in : w_strb_reg;
    bvalid_next = bvalid_reg ? ~s_axi_bready_in : do_write;
    bresp_next = do_write ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_reg;
    rvalid_next = rvalid_reg ? ~s_axi_rready_in : ar_take;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rresp_next = RESP_OKAY;
      unique case (s_axi_araddr_in)
        OFS_CTRL0: rdata_next = DATA_W'({on_reg, 3'h0});
        OFS_CTRL1: rdata_next = DATA_W'(ctrl1_reg);
        OFS_COUNT: rdata_next = DATA_W'(count);
        OFS_COMPA: rdata_next = DATA_W'(compa_reg);
        OFS_COMPP: rdata_next = DATA_W'(compp_reg);
        OFS_FLAGS: rdata_next = DATA_W'({flag_p_reg, flag_a_reg});
        default: begin
          rdata_next = '0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // Control registers and flags
  assign flag_clr = do_write & w_strb_reg[0] & (aw_addr_reg == OFS_FLAGS);

  always_comb begin
    on_next = on_reg;
    ctrl1_next = ctrl1_reg;
    compa_next = compa_reg;
    compp_next = compp_reg;
    // Match A ends a single pulse by dropping counter-on
    if (single & match.a) begin
      on_next = 1'b0;
    end
    if (do_write) begin
      if ((aw_addr_reg == OFS_CTRL0) && w_strb_reg[0]) begin
        on_next = w_data_reg[CTRL0_ON_BIT];
      end
      if ((aw_addr_reg == OFS_CTRL1) && w_strb_reg[0]) begin
        ctrl1_next = ptm_ctrl1_s'(w_data_reg[7:0]);
      end
      if (aw_addr_reg == OFS_COMPA) begin
        compa_next = merge10(compa_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == OFS_COMPP) begin
        compp_next = merge10(compp_reg, w_data_reg, w_strb_reg);
      end
    end
    // A capture beats a software write landing in the same cycle
    if (cap_evt) begin
      compa_next = count;
    end
    // Write one clears; a new event in the same cycle wins
    flag_a_next = (flag_a_reg & ~(flag_clr & w_data_reg[FLAG_A_BIT])) | a_set;
    flag_p_next = (flag_p_reg & ~(flag_clr & w_data_reg[FLAG_P_BIT])) | p_set;
  end

  // ==========================================================
  // Output pin
  always_comb begin
    level_next = level_reg;
    if (restart) begin
      level_next = ctrl1_reg.init_level;
    end else if (is_cmp & match.a) begin
      unique case (ctrl1_reg.action)
        ACT_NONE: level_next = level_reg;
        ACT_LOW: level_next = 1'b0;
        ACT_HIGH: level_next = 1'b1;
        ACT_TOGGLE: level_next = ~level_reg;
      endcase
    end
    base = level_next;
    if (is_pwm) begin
      // Counter runs regardless of the forced codes
      unique case (ctrl1_reg.action)
        PWM_INACTIVE: base = ~ctrl1_reg.init_level;
        PWM_ACTIVE: base = ctrl1_reg.init_level;
        PWM_WAVE: base = pwm_active ? ctrl1_reg.init_level : ~ctrl1_reg.init_level;
        PWM_SINGLE: base = on_next ? ctrl1_reg.init_level : ~ctrl1_reg.init_level;
      endcase
    end
    pin_next = base ^ ctrl1_reg.invert;
    oe_next = is_cmp | is_pwm;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      on_reg <= 1'b0;
      on_prev_reg <= 1'b0;
      ctrl1_reg <= ptm_ctrl1_s'(CTRL1_RESET);
      compa_reg <= CNT_ZERO;
      compp_reg <= CNT_ZERO;
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
      level_reg <= 1'b0;
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      on_reg <= on_next;
      on_prev_reg <= on_reg;
      ctrl1_reg <= ctrl1_next;
      compa_reg <= compa_next;
      compp_reg <= compp_next;
      flag_a_reg <= flag_a_next;
      flag_p_reg <= flag_p_next;
      level_reg <= level_next;
      pin_reg <= pin_next;
      oe_reg <= oe_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= ~aw_full_next;
      wready_reg <= ~w_full_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign timer_output_pin_out = pin_reg;
  assign timer_output_pin_oe_out = oe_reg;

  // ==========================================================
  // Checks
  chk_cmp_low: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (is_cmp && match.a && !restart && ctrl1_reg.action == ACT_LOW) |=> !level_reg)
    else $error("compare low action did not drive low");

  chk_restart_level: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(on_reg) |=> level_reg == $past(ctrl1_reg.init_level))
    else $error("restart did not restore initial level");

  chk_pwm_force: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (is_pwm && ctrl1_reg.action == PWM_INACTIVE && $stable(ctrl1_reg)) |=>
    pin_reg == $past(force_lvl))
    else $error("forced inactive level wrong");

  chk_pwm_full: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (is_pwm && ctrl1_reg.action == PWM_WAVE && compp_reg != CNT_ZERO &&
     compa_reg >= compp_reg) |=> pin_reg == !$past(force_lvl))
    else $error("full duty not held active");

  chk_cmp_pin: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    is_cmp |=> pin_reg == (level_reg ^ $past(ctrl1_reg.invert)))
    else $error("pin is not level xor invert");

  chk_tc_no_drive: assert property (
    @(posedge clk_in) disable iff (!resetn_in) (is_tc || is_cap) |=> !oe_reg)
    else $error("pin driven in timer or capture mode");

  chk_no_p_flag: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (is_cmp && ctrl1_reg.clr_sel && !flag_p_reg) |=> !flag_p_reg)
    else $error("P flag set with clear select on A");

  chk_flag_set_wins: assert property (
    @(posedge clk_in) disable iff (!resetn_in) a_set |=> flag_a_reg)
    else $error("match A flag lost");

endmodule
